//--- inc/fcds_params.svh
/*
 * constants of the fifo clock domain setup block: register offsets,
 * field positions, reset values and clock figures.
 * assumes: included by its bare name before the package and the modules.
 */
// What this block does
// - with the shared setting on, the common clock source drives both the input and output FIFO sides.
// - in shared mode with the common fast setting on (60 MHz or more) both paths use the high band loop.
// - in shared mode with the common fast setting off (below 60 MHz) both paths use the low band loop.
// - with the shared setting off, separate sources drive each side and the common fast setting is ignored.
// - in separate mode the input path uses the high band loop when its fast setting is on, else the low.
// - in separate mode the output path uses the low band loop when its fast setting is off, else the high.
// - after reset the shared clock domain is the selected configuration.
// - a wide free-running counter on the main clock drives status LED 4 from an upper bit.
// - the FIFO clock comes from the 100 MHz oscillator, passed through or halved to 50 MHz.
`ifndef FCDS_PARAMS_SVH
`define FCDS_PARAMS_SVH

// apb map, byte addresses
`define FCDS_ADDR_W        12
`define FCDS_ADDR_CTRL     12'h000
`define FCDS_ADDR_STATUS   12'h004
`define FCDS_ADDR_COUNT    12'h008

// control register fields
`define FCDS_CTRL_SHARED   0
`define FCDS_CTRL_COMFAST  1
`define FCDS_CTRL_INFAST   2
`define FCDS_CTRL_OUTFAST  3
`define FCDS_CTRL_HALVE    4
`define FCDS_CTRL_W        5

// control reset values
`define FCDS_RST_SHARED    1'b1
`define FCDS_RST_COMFAST   1'b1
`define FCDS_RST_INFAST    1'b1
`define FCDS_RST_OUTFAST   1'b1
`define FCDS_RST_HALVE     1'b0

// status register fields
`define FCDS_STAT_INCOM    0
`define FCDS_STAT_OUTCOM   1
`define FCDS_STAT_INHIGH   2
`define FCDS_STAT_OUTHIGH  3
`define FCDS_STAT_TICK     4
`define FCDS_STAT_LED      5
`define FCDS_STAT_MISMATCH 6

// clock figures in MHz
`define FCDS_OSC_MHZ       100
`define FCDS_FAST_MHZ      60
`define FCDS_HALVE_DIV     2

// blinker
`define FCDS_LED_W         27
`define FCDS_LED_INDEX     4

`endif

//--- inc/fcds_pkg.sv
/*
 * types of the fifo clock domain setup block.
 * assumes: fcds_params.svh is on the include path.
 */
`include "fcds_params.svh"

package fcds_pkg;

	typedef struct packed {
		logic halve;
		logic outputFast;
		logic inputFast;
		logic commonFast;
		logic shared;
	} fcds_cfg_type;

	typedef struct packed {
		logic inputFromCommon;
		logic outputFromCommon;
		logic inputHighBand;
		logic outputHighBand;
	} fcds_route_type;

	typedef struct packed {
		logic commonFifoClockSource;
		logic inputFifoClockSource;
		logic outputFifoClockSource;
	} fcds_src_type;

	typedef enum logic [1:0] {
		FCDS_BUS_IDLE = 2'b01,
		FCDS_BUS_ACK  = 2'b10
	} fcds_bus_type;

endpackage

//--- design/fcds_blinker.sv
/*
 * free-running counter that flashes a status led.
 * assumes: clk, synchronous active-high srst, ce freezes the count.
 */
`timescale 1ns/1ps
`default_nettype none

module fcds_blinker
	import fcds_pkg::*;
#(
	parameter int COUNT_W = `FCDS_LED_W
) (
	input  wire logic               clk,
	input  wire logic               srst,
	input  wire logic               ce,
	output logic [COUNT_W-1:0]      countQ,
	output logic                    ledQ
);

	generate
		if (COUNT_W < 2 || COUNT_W > 32) begin : g_bad_width
			$error("fcds_blinker: COUNT_W must lie in 2..32");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// counter and led

	always_ff @(posedge clk) begin
		if (srst) begin
			countQ <= '0;
		end else if (ce) begin
			countQ <= countQ + {{(COUNT_W-1){1'b0}}, 1'b1};
		end
	end

	// led follows the top bit one cycle late, so it is a flop output
	always_ff @(posedge clk) begin
		if (srst) begin
			ledQ <= 1'b0;
		end else if (ce) begin
			ledQ <= countQ[COUNT_W-1];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	AST_COUNT_STEP: assert property (@(posedge clk) disable iff (srst)
		ce |=> countQ == $past(countQ) + {{(COUNT_W-1){1'b0}}, 1'b1})
		else $error("blinker counter did not advance by one");

	AST_COUNT_HOLD: assert property (@(posedge clk) disable iff (srst)
		!ce |=> $stable(countQ) && $stable(ledQ))
		else $error("blinker moved while clock enable was low");

	AST_LED_TOP: assert property (@(posedge clk) disable iff (srst)
		ce |=> ledQ == $past(countQ[COUNT_W-1]))
		else $error("led does not follow the counter top bit");

endmodule // fcds_blinker

`default_nettype wire

//--- design/fcds_top.sv
/*
 * fifo clock domain setup: apb-controlled selection of a shared or split
 * fifo clock domain, band selection of the lock loop on each fifo clock
 * path, oscillator pass-through or halving, and the flashing status led.
 * assumes: clk is the 100 MHz oscillator clock, srst synchronous, ce
 * freezes all state; the clock tree acts on the route and tick outputs.
 */
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none

module fcds_top
	import fcds_pkg::*;
#(
	parameter int LED_W = `FCDS_LED_W
) (
	input  wire logic                        clk,
	input  wire logic                        srst,
	input  wire logic                        ce,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [`FCDS_ADDR_W-1:0]     paddr,
	input  wire logic [31:0]                 pwdata,
	output logic                             pready,
	output logic [31:0]                      prdata,
	output logic                             pslverr,
	output fcds_route_type                   routeQ,
	output fcds_src_type                     srcQ,
	output logic                             fifoClkEnQ,
	output logic [4:0]                       ledQ
);

	generate
		if (LED_W < 2 || LED_W > 32) begin : g_bad_led
			$error("fcds_top: LED_W must lie in 2..32");
		end
	endgenerate

	localparam int HALF_MHZ = `FCDS_OSC_MHZ / `FCDS_HALVE_DIV;

	fcds_cfg_type        cfgQ;
	fcds_route_type      routeD;
	fcds_bus_type        busQ;
	logic [LED_W-1:0]    ledCount;
	logic                blink;
	logic                mismatchQ;
	logic                accessReq;
	logic                commit;
	logic [31:0]         readWord;
	logic                addrOk;
	logic                writeBad;

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	// band chosen for one path; the common setting wins in shared mode
	function automatic logic pickHigh(input fcds_cfg_type c, input logic ownFast);
		pickHigh = c.shared ? c.commonFast : ownFast;
	endfunction

	// frequency of the fifo clock source in MHz
	function automatic int srcMhz(input fcds_cfg_type c);
		srcMhz = c.halve ? HALF_MHZ : `FCDS_OSC_MHZ;
	endfunction

	function automatic logic isMapped(input logic [`FCDS_ADDR_W-1:0] a);
		isMapped = (a == `FCDS_ADDR_CTRL) || (a == `FCDS_ADDR_STATUS)
			|| (a == `FCDS_ADDR_COUNT);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// apb slave: one wait state, answer in the second access cycle

	assign accessReq = psel && penable;
	assign pready    = (busQ == FCDS_BUS_ACK) && ce;
	assign commit    = accessReq && pready;
	assign addrOk    = isMapped(paddr);
	assign writeBad  = pwrite && (paddr != `FCDS_ADDR_CTRL);

	always_ff @(posedge clk) begin
		if (srst) begin
			busQ <= FCDS_BUS_IDLE;
		end else if (ce) begin
			unique case (busQ)
				FCDS_BUS_IDLE: begin
					if (accessReq) begin
						busQ <= FCDS_BUS_ACK;
					end
				end
				FCDS_BUS_ACK: begin
					busQ <= FCDS_BUS_IDLE;
				end
			endcase
		end
	end

	always_comb begin
		readWord = 32'h0000_0000;
		if (paddr == `FCDS_ADDR_CTRL) begin
			readWord[`FCDS_CTRL_SHARED]  = cfgQ.shared;
			readWord[`FCDS_CTRL_COMFAST] = cfgQ.commonFast;
			readWord[`FCDS_CTRL_INFAST]  = cfgQ.inputFast;
			readWord[`FCDS_CTRL_OUTFAST] = cfgQ.outputFast;
			readWord[`FCDS_CTRL_HALVE]   = cfgQ.halve;
		end else if (paddr == `FCDS_ADDR_STATUS) begin
			readWord[`FCDS_STAT_INCOM]    = routeQ.inputFromCommon;
			readWord[`FCDS_STAT_OUTCOM]   = routeQ.outputFromCommon;
			readWord[`FCDS_STAT_INHIGH]   = routeQ.inputHighBand;
			readWord[`FCDS_STAT_OUTHIGH]  = routeQ.outputHighBand;
			readWord[`FCDS_STAT_TICK]     = fifoClkEnQ;
			readWord[`FCDS_STAT_LED]      = blink;
			readWord[`FCDS_STAT_MISMATCH] = mismatchQ;
		end else if (paddr == `FCDS_ADDR_COUNT) begin
			readWord[LED_W-1:0] = ledCount;
		end
	end

	// read data and error are loaded on entry to the answer cycle
	always_ff @(posedge clk) begin
		if (srst) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (ce && busQ == FCDS_BUS_IDLE && accessReq) begin
			prdata  <= pwrite ? 32'h0000_0000 : readWord;
			pslverr <= !addrOk || writeBad;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// configuration

	always_ff @(posedge clk) begin
		if (srst) begin
			cfgQ.shared     <= `FCDS_RST_SHARED;
			cfgQ.commonFast <= `FCDS_RST_COMFAST;
			cfgQ.inputFast  <= `FCDS_RST_INFAST;
			cfgQ.outputFast <= `FCDS_RST_OUTFAST;
			cfgQ.halve      <= `FCDS_RST_HALVE;
		end else if (commit && pwrite && paddr == `FCDS_ADDR_CTRL) begin
			cfgQ.shared     <= pwdata[`FCDS_CTRL_SHARED];
			cfgQ.commonFast <= pwdata[`FCDS_CTRL_COMFAST];
			cfgQ.inputFast  <= pwdata[`FCDS_CTRL_INFAST];
			cfgQ.outputFast <= pwdata[`FCDS_CTRL_OUTFAST];
			cfgQ.halve      <= pwdata[`FCDS_CTRL_HALVE];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// clock routing and band selection

	always_comb begin
		routeD.inputFromCommon  = cfgQ.shared;
		routeD.outputFromCommon = cfgQ.shared;
		routeD.inputHighBand    = pickHigh(cfgQ, cfgQ.inputFast);
		routeD.outputHighBand   = pickHigh(cfgQ, cfgQ.outputFast);
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			routeQ <= '0;
		end else if (ce) begin
			routeQ <= routeD;
		end
	end

	// flags a band setting that disagrees with the oscillator-derived rate
	always_ff @(posedge clk) begin
		if (srst) begin
			mismatchQ <= 1'b0;
		end else if (ce) begin
			mismatchQ <= (routeD.inputHighBand != (srcMhz(cfgQ) >= `FCDS_FAST_MHZ))
				|| (routeD.outputHighBand != (srcMhz(cfgQ) >= `FCDS_FAST_MHZ));
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// oscillator pass-through or halving

	always_ff @(posedge clk) begin
		if (srst) begin
			fifoClkEnQ <= 1'b0;
		end else if (ce) begin
			fifoClkEnQ <= cfgQ.halve ? !fifoClkEnQ : 1'b1;
		end
	end

	// the tick reaches only the sources the domain setting uses
	always_ff @(posedge clk) begin
		if (srst) begin
			srcQ <= '0;
		end else if (ce) begin
			srcQ.commonFifoClockSource <= cfgQ.halve ? !fifoClkEnQ && cfgQ.shared
				: cfgQ.shared;
			srcQ.inputFifoClockSource  <= cfgQ.halve ? !fifoClkEnQ && !cfgQ.shared
				: !cfgQ.shared;
			srcQ.outputFifoClockSource <= cfgQ.halve ? !fifoClkEnQ && !cfgQ.shared
				: !cfgQ.shared;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// status led

	fcds_blinker #(
		.COUNT_W (LED_W)
	) u_blinker (
		.clk    (clk),
		.srst   (srst),
		.ce     (ce),
		.countQ (ledCount),
		.ledQ   (blink)
	);

	always_comb begin
		ledQ                 = 5'h00;
		ledQ[`FCDS_LED_INDEX] = blink;
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	AST_SHARED_COMMON: assert property (@(posedge clk) disable iff (srst)
		(ce && cfgQ.shared) |=> routeQ.inputFromCommon && routeQ.outputFromCommon)
		else $error("shared mode did not route both sides from the common source");

	AST_SHARED_FAST: assert property (@(posedge clk) disable iff (srst)
		(ce && cfgQ.shared && cfgQ.commonFast)
		|=> routeQ.inputHighBand && routeQ.outputHighBand)
		else $error("shared fast clock did not select the high band loop");

	AST_SHARED_SLOW: assert property (@(posedge clk) disable iff (srst)
		(ce && cfgQ.shared && !cfgQ.commonFast)
		|=> !routeQ.inputHighBand && !routeQ.outputHighBand)
		else $error("shared slow clock did not select the low band loop");

	AST_SPLIT_ROUTE: assert property (@(posedge clk) disable iff (srst)
		(ce && !cfgQ.shared) |=> !routeQ.inputFromCommon && !routeQ.outputFromCommon
		&& !srcQ.commonFifoClockSource)
		else $error("split mode still uses the common source");

	AST_SPLIT_INPUT: assert property (@(posedge clk) disable iff (srst)
		(ce && !cfgQ.shared) |=> routeQ.inputHighBand == $past(cfgQ.inputFast))
		else $error("input band does not follow its own fast setting");

	AST_SPLIT_OUTPUT: assert property (@(posedge clk) disable iff (srst)
		(ce && !cfgQ.shared) |=> routeQ.outputHighBand == $past(cfgQ.outputFast))
		else $error("output band does not follow its own fast setting");

	AST_RESET_SHARED: assert property (@(posedge clk) disable iff (srst)
		$fell(srst) |-> cfgQ.shared && !cfgQ.halve)
		else $error("reset did not select the shared domain");

	AST_FULL_RATE: assert property (@(posedge clk) disable iff (srst)
		(ce && !cfgQ.halve) ##1 (ce && !cfgQ.halve) |=> fifoClkEnQ [*1])
		else $error("undivided oscillator tick dropped");

	AST_HALF_RATE: assert property (@(posedge clk) disable iff (srst)
		(ce && cfgQ.halve) |=> fifoClkEnQ != $past(fifoClkEnQ))
		else $error("halved oscillator tick did not alternate");

	AST_BUS_ANSWER: assert property (@(posedge clk) disable iff (srst)
		(ce && accessReq && busQ == FCDS_BUS_IDLE) |=> busQ == FCDS_BUS_ACK)
		else $error("apb access was not answered in the next cycle");

endmodule // fcds_top

`default_nettype wire

//--- bench/fcds_tree_model.sv
/*
 * model of the fifo clock tree that the block steers: counts the source
 * ticks that reach the common path and the split input and output paths.
 * assumes: route and source levels come from fcds_top on the same clk.
 */
`timescale 1ns/1ps
`default_nettype none

module fcds_tree_model
	import fcds_pkg::*;
(
	input  wire logic           clk,
	input  wire logic           srst,
	input  wire fcds_route_type routeQ,
	input  wire fcds_src_type   srcQ,
	output logic [15:0]         comTicksQ,
	output logic [15:0]         splitTicksQ
);

	// one common source feeds both fifo sides
	always_ff @(posedge clk) begin
		if (srst)
			comTicksQ <= 16'h0000;
		else if (routeQ.inputFromCommon && routeQ.outputFromCommon && srcQ.commonFifoClockSource)
			comTicksQ <= comTicksQ + 16'h0001;
	end

	// each side takes its own source, counted only when both tick
	always_ff @(posedge clk) begin
		if (srst)
			splitTicksQ <= 16'h0000;
		else if (!routeQ.inputFromCommon && srcQ.inputFifoClockSource && srcQ.outputFifoClockSource)
			splitTicksQ <= splitTicksQ + 16'h0001;
	end

endmodule // fcds_tree_model

`default_nettype wire

//--- bench/tb.sv
/*
 * self-checking bench of fcds_top: apb tasks, route table, halving,
 * refusals and the led blinker.
 * assumes: fcds_params.svh on the include path, LED_W shortened to 4.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fcds_params.svh"

module tb
	import fcds_pkg::*;
;
	logic           clk = 1'b0;
	logic           srst = 1'b1;
	logic           ce = 1'b1;
	logic           psel = 1'b0;
	logic           penable = 1'b0;
	logic           pwrite = 1'b0;
	logic [11:0]    paddr = 12'h000;
	logic [31:0]    pwdata = 32'h00000000;
	logic           pready;
	logic [31:0]    prdata;
	logic           pslverr;
	fcds_route_type routeQ;
	fcds_src_type   srcQ;
	logic           fifoClkEnQ;
	logic [4:0]     ledQ;
	logic [15:0]    comTicks;
	logic [15:0]    splTicks;
	logic [31:0]    rd;
	logic           er;
	logic [15:0]    c0;
	logic [15:0]    s0;
	logic           prev;
	int             err_total = 0;
	int             checked = 0;

	always #2.5 clk = ~clk;

	fcds_top #(.LED_W(4)) DUT (.clk(clk), .srst(srst), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .routeQ(routeQ),
		.srcQ(srcQ), .fifoClkEnQ(fifoClkEnQ), .ledQ(ledQ));

	fcds_tree_model tree (.clk(clk), .srst(srst), .routeQ(routeQ), .srcQ(srcQ),
		.comTicksQ(comTicks), .splitTicksQ(splTicks));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] r, output logic e);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge clk);
		penable <= 1'b1;
		// pready only moves after a rising edge, so the level seen at a
		// falling edge is the one sampled at the next rising edge
		@(negedge clk);
		while (pready !== 1'b1) begin
			@(negedge clk);
		end
		@(posedge clk);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic fcds_route_type expRoute(input logic [3:0] c);
		fcds_route_type x;
		x.inputFromCommon = c[0];
		x.outputFromCommon = c[0];
		x.inputHighBand = c[0] ? c[1] : c[2];
		x.outputHighBand = c[0] ? c[1] : c[3];
		return x;
	endfunction

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		fcds_route_type x;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		apb(1'b0, `FCDS_ADDR_CTRL, 32'h0, rd, er);
		chk(rd, 32'h0000000F, "ctrl reset");
		@(negedge clk);
		chk(32'(routeQ), 32'hF, "route after reset");
		$display("test reset done");

		for (int i = 0; i < 16; i++) begin
			apb(1'b1, `FCDS_ADDR_CTRL, 32'(i), rd, er);
			chk(er, 1'b0, "ctrl write accepted");
			repeat (3) @(posedge clk);
			@(negedge clk);
			x = expRoute(4'(i));
			chk(32'(routeQ), 32'(x), "route");
			chk(32'(srcQ), i[0] ? 32'h4 : 32'h3, "sources");
			c0 = comTicks;
			s0 = splTicks;
			repeat (10) @(negedge clk);
			chk(32'(comTicks - c0), i[0] ? 32'd10 : 32'd0, "common ticks");
			chk(32'(splTicks - s0), i[0] ? 32'd0 : 32'd10, "split ticks");
			apb(1'b0, `FCDS_ADDR_STATUS, 32'h0, rd, er);
			chk(rd[4:0], {1'b1, x.outputHighBand, x.inputHighBand, x.outputFromCommon,
				x.inputFromCommon}, "status");
			chk(rd[6], !(x.inputHighBand && x.outputHighBand), "band mismatch");
		end
		$display("test route table done");

		apb(1'b1, `FCDS_ADDR_CTRL, 32'h11, rd, er);
		repeat (3) @(posedge clk);
		@(negedge clk);
		prev = fifoClkEnQ;
		for (int i = 0; i < 6; i++) begin
			@(negedge clk);
			chk(fifoClkEnQ, !prev, "halved enable");
			prev = fifoClkEnQ;
		end
		c0 = comTicks;
		repeat (10) @(negedge clk);
		chk(32'(comTicks - c0), 32'd5, "halved ticks");
		apb(1'b1, `FCDS_ADDR_CTRL, 32'h01, rd, er);
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk(fifoClkEnQ, 1'b1, "pass-through enable");
		$display("test halving done");

		apb(1'b1, `FCDS_ADDR_STATUS, 32'h0, rd, er);
		chk(er, 1'b1, "write to status refused");
		apb(1'b0, 12'h00C, 32'h0, rd, er);
		chk(er, 1'b1, "unmapped read error");
		chk(rd, 32'h0, "unmapped read data");
		apb(1'b0, `FCDS_ADDR_CTRL, 32'h0, rd, er);
		chk(er, 1'b0, "ctrl read error");
		chk(rd, 32'h01, "ctrl kept");
		$display("test refusals done");

		srst <= 1'b1;
		@(posedge clk);
		srst <= 1'b0;
		apb(1'b0, `FCDS_ADDR_CTRL, 32'h0, rd, er);
		chk(rd, 32'h0000000F, "ctrl after second reset");
		@(negedge clk);
		chk(32'(routeQ), 32'hF, "route after second reset");
		$display("test second reset done");

		prev = ledQ[4];
		c0 = 16'h0000;
		for (int i = 0; i < 32; i++) begin
			@(negedge clk);
			if (ledQ[4] !== prev)
				c0++;
			prev = ledQ[4];
			chk(ledQ[3:0], 4'h0, "spare leds");
		end
		chk(c0, 32'd4, "led toggles");
		apb(1'b0, `FCDS_ADDR_COUNT, 32'h0, rd, er);
		chk(rd[31:4], 28'h0, "count width");
		s0 = 16'(rd);
		// eight frozen cycles between the two reads; only four live ones count
		ce <= 1'b0;
		repeat (8) @(posedge clk);
		ce <= 1'b1;
		apb(1'b0, `FCDS_ADDR_COUNT, 32'h0, rd, er);
		chk(4'(rd[3:0] - s0[3:0]), 32'h4, "count frozen while ce low");
		$display("test blinker done");
		end_sim();
	end

	initial begin
		#20000;
		err_total++;
		end_sim();
	end

endmodule // tb

`default_nettype wire
